// >>> access_ctrl_pkg.sv
package access_ctrl_pkg;
	// privilege levels, lowest first so the value indexes the tables
	typedef enum logic [1:0] {
		least_privilege_level,
		os_privilege_level,
		top_privilege_level
	} priv_t;
	// loader life cycle
	typedef enum logic [1:0] {ldr_boot, ldr_open, ldr_blocked} ldr_state_t;
	// loader roles
	typedef enum logic {role_vendor, role_customer} role_t;

	// bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int SFR_W = 8;

	// access kinds, also the bit index in a rights word
	localparam logic [1:0] KIND_READ = 2'h0;
	localparam logic [1:0] KIND_WRITE = 2'h1;
	localparam logic [1:0] KIND_EXEC = 2'h2;

	// memory regions
	localparam logic [1:0] RGN_TEST = 2'h0;
	localparam logic [1:0] RGN_SUPPORT = 2'h1;
	localparam logic [1:0] RGN_OS = 2'h2;
	localparam logic [1:0] RGN_USER = 2'h3;
	localparam logic [ADDR_W-1:0] SUPPORT_BASE = 16'h1000;
	localparam logic [ADDR_W-1:0] OS_BASE = 16'h2000;
	localparam logic [ADDR_W-1:0] USER_BASE = 16'h8000;
	localparam logic [ADDR_W-1:0] HOLE_BASE = 16'hE000;

	// fixed sandbox window for least-level code of party a
	localparam logic [ADDR_W-1:0] BOX_BASE = 16'h8000;
	localparam logic [ADDR_W-1:0] BOX_LIMIT = 16'hBFFF;

	// register groups: top two offset bits, only low offsets populated
	localparam logic [1:0] GRP_TEST = 2'h0;
	localparam logic [1:0] GRP_SECURITY = 2'h1;
	localparam logic [1:0] GRP_PERIPH = 2'h2;
	localparam logic [1:0] GRP_USER_IO = 2'h3;
	localparam logic [5:0] GRP_USED = 6'h30;

	// rights per region and level: bit0 read, bit1 write, bit2 execute
	localparam logic [0:3][0:2][2:0] MEM_PERM = '{
		'{3'h0, 3'h0, 3'h7},
		'{3'h0, 3'h0, 3'h7},
		'{3'h0, 3'h7, 3'h3},
		'{3'h7, 3'h3, 3'h3}
	};
	// rights per register group and level: bit0 read, bit1 write
	localparam logic [0:3][0:2][1:0] SFR_PERM = '{
		'{2'h0, 2'h0, 2'h3},
		'{2'h0, 2'h3, 2'h3},
		'{2'h3, 2'h3, 2'h3},
		'{2'h3, 2'h3, 2'h1}
	};
	// groups that also need ownership
	localparam logic [0:3] GRP_OWNED = 4'h2;

	// loader rights per role: bit0 load, bit1 lock
	localparam logic [1:0] LDR_OP_LOAD = 2'h0;
	localparam logic [1:0] LDR_OP_LOCK = 2'h1;
	localparam logic [0:1][1:0] LDR_RIGHTS = '{2'h2, 2'h1};

	// fault counting
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] MAJOR_MAX = 8'h03;
	// cycles the pin synchronisers need before a strap is trusted
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage : access_ctrl_pkg

// >>> access_region_decode.sv
`timescale 1ns/10ps
`default_nettype none
module access_region_decode (
	// request address
	input wire logic [access_ctrl_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [access_ctrl_pkg::SFR_W-1:0] sfr_addr,
	// decoded memory side
	output logic [1:0] mem_region,
	output logic mem_impl,
	// decoded register side
	output logic [1:0] sfr_group,
	output logic sfr_impl
);
	// fixed map, nothing here is loadable
	always_comb begin
		mem_impl = (mem_addr < access_ctrl_pkg::HOLE_BASE);
		if (mem_addr >= access_ctrl_pkg::USER_BASE) begin
			mem_region = access_ctrl_pkg::RGN_USER;
		end else if (mem_addr >= access_ctrl_pkg::OS_BASE) begin
			mem_region = access_ctrl_pkg::RGN_OS;
		end else if (mem_addr >= access_ctrl_pkg::SUPPORT_BASE) begin
			mem_region = access_ctrl_pkg::RGN_SUPPORT;
		end else begin
			mem_region = access_ctrl_pkg::RGN_TEST;
		end
		// group is the top offset pair, gaps above the used slots
		sfr_group = sfr_addr[7:6];
		sfr_impl = (sfr_addr[5:0] < access_ctrl_pkg::GRP_USED);
	end
endmodule : access_region_decode
`default_nettype wire

// >>> fault_severity_counter.sv
`timescale 1ns/10ps
`default_nettype none
module fault_severity_counter #(
	parameter logic [access_ctrl_pkg::CNT_W-1:0] MAJOR_MAX = access_ctrl_pkg::MAJOR_MAX
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// fault events, one cycle each
	input wire logic minor_evt,
	input wire logic major_evt,
	// counts and verdict
	output logic [access_ctrl_pkg::CNT_W-1:0] minor_count,
	output logic [access_ctrl_pkg::CNT_W-1:0] major_count,
	output logic chip_disabled
);
	logic [access_ctrl_pkg::CNT_W-1:0] next_minor_count;
	logic [access_ctrl_pkg::CNT_W-1:0] next_major_count;
	logic next_chip_disabled;

	// saturate so a flood of faults never wraps back to a clean count
	always_comb begin
		next_minor_count = minor_count;
		next_major_count = major_count;
		if (minor_evt && (minor_count != '1)) begin
			next_minor_count = minor_count + 1'b1;
		end
		if (major_evt && (major_count != '1)) begin
			next_major_count = major_count + 1'b1;
		end
		// disabling is one-way
		next_chip_disabled = chip_disabled | (next_major_count > MAJOR_MAX);
	end

	// counts survive security resets, only power-on clears them
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			minor_count <= '0;
			major_count <= '0;
			chip_disabled <= 1'b0;
		end else begin
			minor_count <= next_minor_count;
			major_count <= next_major_count;
			chip_disabled <= next_chip_disabled;
		end
	end
endmodule : fault_severity_counter
`default_nettype wire

// >>> privilege_access_control.sv
// How it works
// - three levels, each with own region rights
// - rights are constants, nothing can rewrite them
// - customer code never touches test region
// - each register checked for read/write per level
// - registers grouped, one rights set per group
// - owned groups also need matching owner party below top level
// - test registers locked for good after test
// - bad register access resets and counts fault
// - level changes only by instruction or interrupt
// - party a least level boxed in fixed window
// - loader gated by role rights and state
// - loader blocked after use or if unselected
// - unimplemented memory access also forces reset
// - two fault severities, major count has limit
`timescale 1ns/10ps
`default_nettype none
module privilege_access_control #(
	parameter logic [access_ctrl_pkg::CNT_W-1:0] MAJOR_MAX = access_ctrl_pkg::MAJOR_MAX
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// pins: end-of-test fuse and loader select strap
	input wire logic test_done_pin,
	input wire logic loader_sel_pin,
	// level control from the cpu
	input wire logic mode_drop_valid,
	input wire logic [1:0] mode_drop_to,
	input wire logic irq_enter,
	input wire logic irq_return,
	// running party, low is party a
	input wire logic party_b,
	// ownership claim instruction
	input wire logic claim_valid,
	input wire logic [1:0] claim_group,
	// access request
	input wire logic acc_valid,
	input wire logic acc_sfr,
	input wire logic [1:0] acc_kind,
	input wire logic [access_ctrl_pkg::ADDR_W-1:0] acc_addr,
	input wire logic [access_ctrl_pkg::DATA_W-1:0] acc_rdata,
	// access answer
	output logic acc_grant,
	output logic acc_deny,
	output logic [access_ctrl_pkg::DATA_W-1:0] cpu_rdata,
	output logic sec_reset,
	// loader requests
	input wire logic ldr_req,
	input wire logic ldr_role,
	input wire logic [1:0] ldr_op,
	input wire logic ldr_done,
	output logic ldr_grant,
	output logic [1:0] ldr_state_out,
	// status
	output logic [1:0] cur_mode_out,
	output logic test_locked,
	output logic [access_ctrl_pkg::CNT_W-1:0] minor_count,
	output logic [access_ctrl_pkg::CNT_W-1:0] major_count,
	output logic chip_disabled
);
	// pin synchronisers: three stages, trusted when stages two and three agree
	logic [1:0] pin_raw;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] pin_stable;
	logic [1:0] next_pin_stable;
	assign pin_raw = {loader_sel_pin, test_done_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			// stage one feeds stage two only
			always_comb begin
				next_pin_stable[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : pin_stable[gi];
			end
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					pin_stable[gi] <= 1'b0;
				end else begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					pin_stable[gi] <= next_pin_stable[gi];
				end
			end
		end
	endgenerate

	// address decode
	logic [1:0] mem_region;
	logic mem_impl;
	logic [1:0] sfr_group;
	logic sfr_impl;
	access_region_decode i_access_region_decode (
		.mem_addr(acc_addr),
		.sfr_addr(acc_addr[access_ctrl_pkg::SFR_W-1:0]),
		.mem_region(mem_region),
		.mem_impl(mem_impl),
		.sfr_group(sfr_group),
		.sfr_impl(sfr_impl)
	);

	// level state
	access_ctrl_pkg::priv_t cur_mode;
	access_ctrl_pkg::priv_t next_cur_mode;
	access_ctrl_pkg::priv_t saved_mode;
	access_ctrl_pkg::priv_t next_saved_mode;
	logic next_test_locked;
	logic [0:3] owner;
	logic [0:3] next_owner;

	// level only moves on an instruction or interrupt edge
	always_comb begin
		next_cur_mode = cur_mode;
		next_saved_mode = saved_mode;
		if (irq_enter) begin
			// handlers run at least at os level
			next_saved_mode = cur_mode;
			if (cur_mode != access_ctrl_pkg::top_privilege_level) begin
				next_cur_mode = access_ctrl_pkg::os_privilege_level;
			end
		end else if (irq_return) begin
			next_cur_mode = saved_mode;
		end else if (mode_drop_valid && (mode_drop_to < cur_mode)) begin
			// instructions may only lower the level, never raise it
			next_cur_mode = access_ctrl_pkg::priv_t'(mode_drop_to);
		end
		// fuse once seen keeps the lock, only reset_n clears it
		next_test_locked = test_locked | pin_stable[0];
		next_owner = owner;
		// least level cannot take ownership
		if (claim_valid && (cur_mode != access_ctrl_pkg::least_privilege_level)) begin
			next_owner[claim_group] = party_b;
		end
	end

	// boot in top level so support code runs first
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_mode <= access_ctrl_pkg::top_privilege_level;
			saved_mode <= access_ctrl_pkg::top_privilege_level;
			test_locked <= 1'b0;
			owner <= 4'h0;
		end else begin
			cur_mode <= next_cur_mode;
			saved_mode <= next_saved_mode;
			test_locked <= next_test_locked;
			owner <= next_owner;
		end
	end

	// access check, all from constant tables
	logic [2:0] mem_rights;
	logic [1:0] sfr_rights;
	logic box_ok;
	logic mem_ok;
	logic sfr_ok;
	logic access_ok;
	logic unimpl;
	always_comb begin
		mem_rights = access_ctrl_pkg::MEM_PERM[mem_region][cur_mode];
		sfr_rights = access_ctrl_pkg::SFR_PERM[sfr_group][cur_mode];
		// party a least-level code stays in its fixed window
		box_ok = (cur_mode != access_ctrl_pkg::least_privilege_level) || party_b
			|| ((acc_addr >= access_ctrl_pkg::BOX_BASE)
			&& (acc_addr <= access_ctrl_pkg::BOX_LIMIT));
		// kind 3 is no access at all, refuse it rather than index past the rights word
		mem_ok = mem_impl && (acc_kind <= access_ctrl_pkg::KIND_EXEC)
			&& mem_rights[acc_kind] && box_ok;
		// test region only for top level and only before lock
		if (mem_region == access_ctrl_pkg::RGN_TEST) begin
			mem_ok = mem_ok && !test_locked
				&& (cur_mode == access_ctrl_pkg::top_privilege_level);
		end
		// registers cannot be executed
		sfr_ok = sfr_impl && (acc_kind < access_ctrl_pkg::KIND_EXEC)
			&& sfr_rights[acc_kind[0]];
		if (sfr_group == access_ctrl_pkg::GRP_TEST) begin
			sfr_ok = sfr_ok && !test_locked;
		end
		// top level may reach owned groups regardless of owner
		if (access_ctrl_pkg::GRP_OWNED[sfr_group]
			&& (cur_mode != access_ctrl_pkg::top_privilege_level)) begin
			sfr_ok = sfr_ok && (owner[sfr_group] == party_b);
		end
		unimpl = acc_sfr ? !sfr_impl : !mem_impl;
		access_ok = acc_sfr ? sfr_ok : mem_ok;
	end

	// a disabled chip or one in reset grants no memory or register access
	always_comb begin
		acc_grant = acc_valid && access_ok && !chip_disabled && !sec_reset;
		acc_deny = acc_valid && !sec_reset && (!access_ok || chip_disabled);
	end

	// fault severities: unimplemented targets count as major
	fault_severity_counter #(
		.MAJOR_MAX(MAJOR_MAX)
	) i_fault_severity_counter (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.minor_evt(acc_deny && !unimpl),
		.major_evt(acc_deny && unimpl),
		.minor_count(minor_count),
		.major_count(major_count),
		.chip_disabled(chip_disabled)
	);

	// answer registers
	logic [access_ctrl_pkg::DATA_W-1:0] next_cpu_rdata;
	logic next_sec_reset;
	always_comb begin
		// protected data never leaves on a refused read
		next_cpu_rdata = '0;
		if (acc_grant && (acc_kind == access_ctrl_pkg::KIND_READ)) begin
			next_cpu_rdata = acc_rdata;
		end
		next_sec_reset = acc_deny;
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_rdata <= '0;
			sec_reset <= 1'b0;
		end else begin
			cpu_rdata <= next_cpu_rdata;
			sec_reset <= next_sec_reset;
		end
	end

	// loader life cycle, strap read once the synchroniser settles
	access_ctrl_pkg::ldr_state_t ldr_state;
	access_ctrl_pkg::ldr_state_t next_ldr_state;
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic [1:0] role_rights;
	always_comb begin
		next_ldr_state = ldr_state;
		next_settle = settle;
		role_rights = access_ctrl_pkg::LDR_RIGHTS[ldr_role];
		// least level may not drive the loader at all
		ldr_grant = ldr_req && (ldr_state == access_ctrl_pkg::ldr_open)
			&& (cur_mode != access_ctrl_pkg::least_privilege_level)
			// undefined op codes get nothing, so every grant matches a decoded op
			&& !ldr_op[1] && role_rights[ldr_op[0]];
		case (ldr_state)
			access_ctrl_pkg::ldr_boot: begin
				if (settle == access_ctrl_pkg::STRAP_SETTLE) begin
					// agreed stages now, the registered copy lands one edge too late
					next_ldr_state = next_pin_stable[1] ? access_ctrl_pkg::ldr_open
						: access_ctrl_pkg::ldr_blocked;
				end else begin
					next_settle = settle + 1'b1;
				end
			end
			access_ctrl_pkg::ldr_open: begin
				// customer finish or vendor lock ends it for good
				if ((ldr_done && (ldr_role == access_ctrl_pkg::role_customer))
					|| (ldr_grant && (ldr_op == access_ctrl_pkg::LDR_OP_LOCK))) begin
					next_ldr_state = access_ctrl_pkg::ldr_blocked;
				end
			end
			access_ctrl_pkg::ldr_blocked: begin
				next_ldr_state = access_ctrl_pkg::ldr_blocked;
			end
			default: begin
				next_ldr_state = access_ctrl_pkg::ldr_blocked;
			end
		endcase
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ldr_state <= access_ctrl_pkg::ldr_boot;
			settle <= 2'h0;
		end else begin
			ldr_state <= next_ldr_state;
			settle <= next_settle;
		end
	end
	assign ldr_state_out = ldr_state;
	assign cur_mode_out = cur_mode;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_deny_resets: assert property (acc_deny |=> sec_reset && cpu_rdata == '0)
		else $error("denied access did not force reset");
	a_reset_cause: assert property (sec_reset |-> $past(acc_deny))
		else $error("reset without denied access");
	a_grant_excl: assert property (!(acc_grant && acc_deny))
		else $error("grant and deny together");
	a_test_lock_sticky: assert property (test_locked |=> test_locked)
		else $error("test lock released");
	a_test_region: assert property (acc_grant && !acc_sfr && mem_region == 2'h0
		|-> cur_mode == access_ctrl_pkg::top_privilege_level && !test_locked)
		else $error("test region granted wrongly");
	a_test_group: assert property (acc_grant && acc_sfr && sfr_group == 2'h0
		|-> !test_locked)
		else $error("test register granted after lock");
	a_mode_cause: assert property ($changed(cur_mode)
		|-> $past(irq_enter || irq_return || mode_drop_valid))
		else $error("level changed without cause");
	a_mode_raise: assert property (mode_drop_valid && !irq_enter && !irq_return
		|=> cur_mode <= $past(cur_mode))
		else $error("instruction raised level");
	a_box_hold: assert property (acc_grant && !acc_sfr && !party_b
		&& cur_mode == access_ctrl_pkg::least_privilege_level
		|-> acc_addr >= 16'h8000 && acc_addr <= 16'hBFFF)
		else $error("box escape granted");
	a_ldr_blocked: assert property (ldr_state == access_ctrl_pkg::ldr_blocked
		|=> ldr_state == access_ctrl_pkg::ldr_blocked && !ldr_grant)
		else $error("loader left blocked state");
	a_ldr_role: assert property (ldr_grant |-> ldr_state == access_ctrl_pkg::ldr_open
		&& !ldr_op[1] && access_ctrl_pkg::LDR_RIGHTS[ldr_role][ldr_op[0]]
		&& cur_mode != access_ctrl_pkg::least_privilege_level)
		else $error("loader granted without rights");
	a_major_count: assert property (acc_deny && unimpl && major_count != 8'hFF
		|=> major_count == $past(major_count) + 8'h01)
		else $error("major fault not counted");
	a_user_support: assert property (acc_grant && !acc_sfr && mem_region == 2'h1
		|-> cur_mode == access_ctrl_pkg::top_privilege_level)
		else $error("support region granted below top");

	c_user_read: cover property (acc_grant && cur_mode == access_ctrl_pkg::least_privilege_level);
	c_deny_reset: cover property (acc_deny ##1 sec_reset);
	c_irq_round: cover property (irq_enter ##[1:20] irq_return);
	c_ldr_block: cover property (ldr_state == access_ctrl_pkg::ldr_open
		##1 ldr_state == access_ctrl_pkg::ldr_blocked);
endmodule : privilege_access_control
`default_nettype wire

// >>> cpu_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// cpu side: turns bench commands into one-cycle bus accesses
module cpu_core_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// command from the bench
	input wire logic cmd_valid,
	input wire logic cmd_sfr,
	input wire logic [1:0] cmd_kind,
	input wire logic [15:0] cmd_addr,
	input wire logic [31:0] cmd_data,
	// bus toward the access unit
	output logic acc_valid,
	output logic acc_sfr,
	output logic [1:0] acc_kind,
	output logic [15:0] acc_addr,
	output logic [31:0] acc_rdata
);
	// released address and data lines flip every cycle so stale data never passes for fresh; kind and sfr hold
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_valid <= 1'b0;
			acc_sfr <= 1'b0;
			acc_kind <= 2'h0;
			acc_addr <= 16'h0;
			acc_rdata <= 32'h0;
		end else if (cmd_valid) begin
			acc_valid <= 1'b1;
			acc_sfr <= cmd_sfr;
			acc_kind <= cmd_kind;
			acc_addr <= cmd_addr;
			acc_rdata <= cmd_data;
		end else begin
			acc_valid <= 1'b0;
			acc_addr <= ~acc_addr;
			acc_rdata <= ~acc_rdata;
		end
	end
endmodule : cpu_core_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin fails++; $display("BAD %0t %s", $time, m); end end
module tb;
	localparam logic [7:0] MAJ = 8'h01; // short fault limit keeps the run brief
	// design and model hookup
	logic ref_clk, reset_n, test_done_pin, loader_sel_pin, mode_drop_valid, irq_enter, irq_return;
	logic party_b, claim_valid, acc_valid, acc_sfr, cmd_valid, cmd_sfr, acc_grant, acc_deny;
	logic sec_reset, ldr_req, ldr_role, ldr_done, ldr_grant, test_locked, chip_disabled;
	logic [1:0] mode_drop_to, claim_group, acc_kind, cmd_kind, ldr_op, ldr_state_out, cur_mode_out;
	logic [15:0] acc_addr, cmd_addr;
	logic [31:0] acc_rdata, cmd_data, cpu_rdata;
	logic [7:0] minor_count, major_count;
	// bench bookkeeping
	typedef struct {logic deny; logic cc; logic [31:0] data; logic [7:0] mn; logic [7:0] mj;} note_t;
	note_t notes[$];
	note_t pn;
	bit pend;
	int fails, total_checks, cyc;
	logic [31:0] rnd;
	logic [1:0] exp_lvl, saved, ldr_st;
	logic owner [0:3];
	logic pb, locked, disabled;
	logic [7:0] mn, mj;
	logic [15:0] rbase [0:3] = '{16'h0000, 16'h1000, 16'h2000, 16'h8000};

	cpu_core_model i_cpu_core_model (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_sfr(cmd_sfr), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.acc_valid(acc_valid), .acc_sfr(acc_sfr), .acc_kind(acc_kind), .acc_addr(acc_addr),
		.acc_rdata(acc_rdata));
	privilege_access_control #(.MAJOR_MAX(MAJ)) i_privilege_access_control (.ref_clk(ref_clk),
		.reset_n(reset_n), .test_done_pin(test_done_pin), .loader_sel_pin(loader_sel_pin),
		.mode_drop_valid(mode_drop_valid), .mode_drop_to(mode_drop_to), .irq_enter(irq_enter),
		.irq_return(irq_return), .party_b(party_b), .claim_valid(claim_valid),
		.claim_group(claim_group), .acc_valid(acc_valid), .acc_sfr(acc_sfr), .acc_kind(acc_kind),
		.acc_addr(acc_addr), .acc_rdata(acc_rdata), .acc_grant(acc_grant), .acc_deny(acc_deny),
		.cpu_rdata(cpu_rdata), .sec_reset(sec_reset), .ldr_req(ldr_req), .ldr_role(ldr_role),
		.ldr_op(ldr_op), .ldr_done(ldr_done), .ldr_grant(ldr_grant),
		.ldr_state_out(ldr_state_out), .cur_mode_out(cur_mode_out), .test_locked(test_locked),
		.minor_count(minor_count), .major_count(major_count), .chip_disabled(chip_disabled));

	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// hang guard, well above the few hundred cycles needed
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	// watcher: answer in the access cycle, data and counts one cycle on
	always @(negedge ref_clk) begin
		if (pend) begin
			`CHK(cpu_rdata, pn.data, "read data")
			`CHK(sec_reset, pn.deny, "reset pulse")
			if (pn.cc) `CHK({minor_count, major_count}, {pn.mn, pn.mj}, "fault counts")
			pend = 1'b0;
		end
		if (!reset_n) pend = 1'b0;
		else if (acc_valid) begin
			pn = notes.pop_front();
			`CHK({acc_grant, acc_deny}, {~pn.deny, pn.deny}, "access verdict")
			pend = 1'b1;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	// expected verdict: bit1 major, bit0 deny
	function automatic logic [1:0] judge(input logic sfr, input logic [1:0] k, input logic [15:0] a);
		logic ok;
		logic [1:0] g;
		int r;
		g = a[7:6];
		if (disabled) return 2'b01; // dead chip refuses all
		if (sfr) begin
			if (a[5:0] >= access_ctrl_pkg::GRP_USED) return 2'b11;
			ok = k != access_ctrl_pkg::KIND_EXEC && access_ctrl_pkg::SFR_PERM[g][exp_lvl][k[0]];
			if (g == access_ctrl_pkg::GRP_TEST && locked) ok = 1'b0;
			if (access_ctrl_pkg::GRP_OWNED[g] && exp_lvl != 2'h2 && owner[g] != pb) ok = 1'b0;
		end else begin
			if (a >= access_ctrl_pkg::HOLE_BASE) return 2'b11;
			r = a < 16'h1000 ? 0 : a < 16'h2000 ? 1 : a < 16'h8000 ? 2 : 3;
			ok = access_ctrl_pkg::MEM_PERM[r][exp_lvl][k];
			if (!pb && exp_lvl == 2'h0 && (a < 16'h8000 || a > 16'hBFFF)) ok = 1'b0;
		end
		return {1'b0, !ok};
	endfunction : judge

	// one access; keep leaves the bus busy for a back-to-back follower
	task automatic acc(input logic sfr, input logic [1:0] k, input logic [15:0] a, input bit keep);
		note_t n;
		logic [1:0] j;
		rnd = lfsr(rnd);
		j = judge(sfr, k, a);
		n.cc = !disabled;
		if (j[0] && !disabled) begin
			if (j[1]) mj++;
			else mn++;
		end
		disabled = disabled | (mj > MAJ);
		n.deny = j[0];
		n.mn = mn;
		n.mj = mj;
		n.data = (!j[0] && k == access_ctrl_pkg::KIND_READ) ? rnd : 32'h0;
		notes.push_back(n);
		cmd_valid <= 1'b1;
		cmd_sfr <= sfr;
		cmd_kind <= k;
		cmd_addr <= a;
		cmd_data <= rnd;
		@(posedge ref_clk);
		// a deny needs the reset cycle to pass before the next request
		if (j[0] || !keep) begin
			cmd_valid <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask : acc
	// every region with read, write and execute and every group with read and write at the current level
	task automatic sweep();
		for (int r = 0; r < 4; r++)
			for (int k = 0; k < 3; k++) acc(1'b0, k[1:0], rbase[r] | {8'h00, rnd[7:0]}, 1'b1);
		for (int g = 0; g < 4; g++)
			for (int k = 0; k < 2; k++) acc(1'b1, k[1:0], {8'h00, g[1:0], 2'b00, rnd[3:0]}, 1'b1);
		cmd_valid <= 1'b0;
		@(posedge ref_clk);
	endtask : sweep
	// op 0 interrupt entry, 1 interrupt return, 2 drop instruction
	task automatic lvl(input int op, input logic [1:0] to);
		logic [1:0] e;
		e = op == 0 ? (exp_lvl == 2'h2 ? 2'h2 : 2'h1) : op == 1 ? saved : (to < exp_lvl ? to : exp_lvl);
		if (op == 0) saved = exp_lvl;
		irq_enter <= op == 0;
		irq_return <= op == 1;
		mode_drop_valid <= op == 2;
		mode_drop_to <= to;
		@(posedge ref_clk);
		irq_enter <= 1'b0;
		irq_return <= 1'b0;
		mode_drop_valid <= 1'b0;
		@(negedge ref_clk) `CHK(cur_mode_out, e, "level")
		exp_lvl = e;
		@(posedge ref_clk);
	endtask : lvl
	task automatic setb(input logic v);
		pb = v;
		party_b <= v;
	endtask : setb
	// claims are ignored at the least level
	task automatic claim(input logic [1:0] g);
		claim_valid <= 1'b1;
		claim_group <= g;
		@(posedge ref_clk) claim_valid <= 1'b0;
		@(posedge ref_clk);
		if (exp_lvl != 2'h0) owner[g] = pb;
	endtask : claim
	task automatic ldr(input logic role, input logic [1:0] op);
		logic e;
		e = ldr_st == 2'h1 && exp_lvl != 2'h0 && !op[1] && access_ctrl_pkg::LDR_RIGHTS[role][op[0]];
		ldr_req <= 1'b1;
		ldr_role <= role;
		ldr_op <= op;
		@(negedge ref_clk) `CHK(ldr_grant, e, "loader grant")
		@(posedge ref_clk) ldr_req <= 1'b0;
		if (e && !role) ldr_st = 2'h2;
		@(negedge ref_clk) `CHK(ldr_state_out, ldr_st, "loader state")
		@(posedge ref_clk);
	endtask : ldr
	task automatic do_reset(input logic strap);
		reset_n <= 1'b0;
		loader_sel_pin <= strap;
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		exp_lvl = 2'h2;
		saved = 2'h2;
		ldr_st = strap ? 2'h1 : 2'h2;
		owner = '{default: 1'b0};
		locked = 1'b0;
		disabled = 1'b0;
		mn = 8'h00;
		mj = 8'h00;
		@(negedge ref_clk) `CHK({cur_mode_out, test_locked, chip_disabled}, 4'h8, "reset state")
		`CHK({minor_count, major_count, ldr_state_out}, 18'h0, "reset counts")
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk) `CHK(ldr_state_out, ldr_st, "loader state")
		@(posedge ref_clk);
	endtask : do_reset
	task automatic tally_and_finish();
		if (fails == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// main sequence
	initial begin
		reset_n = 1'b0;
		{test_done_pin, mode_drop_valid, irq_enter, irq_return, claim_valid, cmd_valid} = 6'h0;
		{ldr_req, ldr_role, ldr_done, cmd_sfr} = 4'h0;
		{mode_drop_to, claim_group, cmd_kind, ldr_op} = 8'h0;
		loader_sel_pin = 1'b1;
		party_b = 1'b1;
		pb = 1'b1;
		cmd_addr = 16'h0;
		cmd_data = 32'h0;
		rnd = 32'hAE8E;
		@(posedge ref_clk);
		do_reset(1'b1);
		sweep();
		acc(1'b0, 2'h0, 16'hE123, 1'b0);
		lvl(0, 2'h0);
		lvl(2, 2'h1);
		sweep();
		acc(1'b1, 2'h2, 16'h0085, 1'b0);
		claim(2'h2);
		acc(1'b1, 2'h0, 16'h0081, 1'b0);
		ldr(1'b0, 2'h0);
		ldr(1'b1, 2'h1);
		ldr(1'b1, 2'h0);
		lvl(2, 2'h2);
		lvl(2, 2'h0);
		sweep();
		ldr(1'b1, 2'h0);
		setb(1'b0);
		claim(2'h2);
		acc(1'b0, 2'h0, 16'h8000 | {8'h00, rnd[7:0]}, 1'b0);
		acc(1'b0, 2'h0, 16'hC000 | {8'h00, rnd[7:0]}, 1'b0);
		acc(1'b1, 2'h0, 16'h0083, 1'b0);
		setb(1'b1);
		acc(1'b1, 2'h0, 16'h0082, 1'b0);
		lvl(0, 2'h0);
		ldr(1'b0, 2'h1);
		ldr(1'b1, 2'h0);
		lvl(1, 2'h0);
		acc(1'b1, 2'h0, 16'h003F, 1'b0);
		@(negedge ref_clk) `CHK(chip_disabled, 1'b1, "disable")
		@(posedge ref_clk);
		acc(1'b0, 2'h0, 16'h8010, 1'b0);
		do_reset(1'b0);
		acc(1'b1, 2'h0, 16'h0004, 1'b0);
		test_done_pin <= 1'b1;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk) `CHK(test_locked, 1'b1, "lock set")
		@(posedge ref_clk) test_done_pin <= 1'b0;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk) `CHK(test_locked, 1'b1, "lock kept")
		@(posedge ref_clk);
		locked = 1'b1;
		acc(1'b1, 2'h0, 16'h0004, 1'b0);
		acc(1'b1, 2'h1, 16'h0004, 1'b0);
		do_reset(1'b1);
		ldr(1'b1, 2'h0);
		ldr_done <= 1'b1;
		@(posedge ref_clk) ldr_done <= 1'b0;
		ldr_st = 2'h2;
		ldr(1'b1, 2'h0);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
